/* rtl/ssr_pkg.sv */
// Constants and carriers for the status, sync and ring output block
// Assumes a single 25 MHz clock; timings are derived from it
package ssr_pkg;
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned T_BLINK_MS = 600;
    localparam int unsigned T_SHORT_MS = 75;
    localparam int unsigned T_LONG_MS = 3000;
    localparam int unsigned T_FLASH_MS = 500;
    localparam int unsigned T_RING_LOW_MS = 1000;
    localparam int unsigned T_RING_HIGH_MS = 4000;
    localparam int unsigned T_NOTICE_MS = 1000;
    localparam int unsigned T_RING_TEXT_MS = 5000;
    localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
    localparam logic MODE_SYNC = 1'b0;
    localparam logic MODE_LED = 1'b1;
    localparam logic MODE_RESET = MODE_SYNC;

    // Module status as seen by the LED logic
    typedef struct packed {
        logic powered_off;
        logic low_power;
        logic searching;
        logic registered;
        logic context_active;
        logic data_exchanged;
        logic call_connected;
    } ssr_status_t;

    // Ring sources
    typedef struct packed {
        logic voice_ringing;
        logic data_ringing;
        logic call_waiting;
        logic notice;
    } ssr_ring_t;

    typedef enum logic [4:0] {
        LED_OFF = 5'b0_0001,
        LED_ON1 = 5'b0_0010,
        LED_GAP1 = 5'b0_0100,
        LED_ON2 = 5'b0_1000,
        LED_REST = 5'b1_0000
    } ssr_led_state_t;
endpackage

/* rtl/ssr_outputs.sv */
// Burst/LED pin driver and ring indicator of the cellular engine
// Assumes status inputs are synchronous to clk and held as levels
// Behaviour
// - The pin has modes 0 and 1, set by command, with mode 0 after reset.
// - In mode 0 the pin is high during a transmit burst and low otherwise.
// - In mode 0 the pulse length is the same for traffic and access bursts.
// - In mode 1 high is LED on, and the pin is low when off or in a low-power state.
// - In mode 1 searching or missing SIM/PIN blinks 600 ms on and 600 ms off.
// - In mode 1 registered and idle repeats 75 ms on then 3 s off.
// - In mode 1 active contexts repeat 75 on, 75 off, 75 on, 3 s off.
// - In mode 1 data exchange raises the pin within 1 s for a 0.5 s flash.
// - In mode 1 a connected call holds the pin steadily high.
// - A ringing voice call cycles the ring line 1 s low then 4 s high.
// - Ringing calls request the textual ring notice every 5 s.
// - A waiting call during an active call holds the ring line low.
// - A ringing data or fax call holds the ring line low continuously.
// - Each unsolicited notice pulses the ring line low for 1 s.
// - The ring line is active low, low meaning call or notice and a wake request.
`timescale 1ns/1ps
`default_nettype none
module ssr_outputs #(
    parameter int unsigned T_BLINK_CYC = ssr_pkg::T_BLINK_MS * ssr_pkg::CYC_PER_MS,
    parameter int unsigned T_SHORT_CYC = ssr_pkg::T_SHORT_MS * ssr_pkg::CYC_PER_MS,
    parameter int unsigned T_LONG_CYC = ssr_pkg::T_LONG_MS * ssr_pkg::CYC_PER_MS,
    parameter int unsigned T_RLOW_CYC = ssr_pkg::T_RING_LOW_MS * ssr_pkg::CYC_PER_MS,
    parameter int unsigned T_RHIGH_CYC = ssr_pkg::T_RING_HIGH_MS * ssr_pkg::CYC_PER_MS
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic mode_wr,
    input wire logic mode_value,
    input wire logic tx_burst,
    input wire ssr_pkg::ssr_status_t status,
    input wire ssr_pkg::ssr_ring_t ring,
    output logic pin_mode,
    output logic burst_led_pin,
    output logic ring_indicator_n,
    output logic ring_text_req
);
    import ssr_pkg::*;

    // Flash, notice and text spans scale with the ring-low span
    localparam longint unsigned RLOW_WIDE = T_RLOW_CYC;
    localparam int unsigned T_FLASH_CYC = 32'(RLOW_WIDE * T_FLASH_MS / T_RING_LOW_MS);
    localparam int unsigned T_NOTICE_CYC = 32'(RLOW_WIDE * T_NOTICE_MS / T_RING_LOW_MS);
    localparam int unsigned T_TEXT_CYC = 32'(RLOW_WIDE * T_RING_TEXT_MS / T_RING_LOW_MS);

    // Down-counter load value, cut to the counter width
    function automatic logic [31:0] load(input int unsigned cyc);
        return (cyc > 0) ? 32'(cyc - 1) : 32'h0000_0000;
    endfunction

    // ------------------------------------------------------------
    // Mode register
    // ------------------------------------------------------------
    logic mode_q, mode_d;
    always_comb begin
        mode_d = mode_q;
        if (mode_wr) begin
            mode_d = mode_value;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= MODE_RESET;
        end else begin
            mode_q <= mode_d;
        end
    end

    // ------------------------------------------------------------
    // LED pattern engine
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        PAT_NONE = 3'd0,
        PAT_SEARCH = 3'd1,
        PAT_REG = 3'd2,
        PAT_CTX = 3'd3,
        PAT_FLASH = 3'd4,
        PAT_STEADY = 3'd5
    } ssr_pat_t;

    ssr_pat_t pat;
    ssr_led_state_t led_q, led_d;
    logic [31:0] lcnt_q, lcnt_d;
    logic [31:0] fcnt_q, fcnt_d;
    logic flash_q, flash_d;
    logic led_out;

    // Off and low power win, then the highest-activity status
    always_comb begin
        pat = PAT_NONE;
        if (status.powered_off || status.low_power) begin
            pat = PAT_NONE;
        end else if (status.call_connected) begin
            pat = PAT_STEADY;
        end else if (flash_q || status.data_exchanged) begin
            pat = PAT_FLASH;
        end else if (status.context_active) begin
            pat = PAT_CTX;
        end else if (status.registered) begin
            pat = PAT_REG;
        end else if (status.searching) begin
            pat = PAT_SEARCH;
        end
    end

    // Flash stretcher: starts at once on exchange, lasts 0.5 s
    always_comb begin
        flash_d = flash_q;
        fcnt_d = fcnt_q;
        // Exchange at expiry restarts the flash
        if (status.data_exchanged && (!flash_q || fcnt_q == 32'h0000_0000)) begin
            flash_d = 1'b1;
            fcnt_d = load(T_FLASH_CYC);
        end else if (flash_q) begin
            if (fcnt_q == 32'h0000_0000) begin
                flash_d = 1'b0;
            end else begin
                fcnt_d = fcnt_q - 32'h0000_0001;
            end
        end
    end

    // Blink sequencer; the counter runs out then steps the state
    always_comb begin
        led_d = led_q;
        lcnt_d = lcnt_q;
        if (pat == PAT_NONE || pat == PAT_STEADY || pat == PAT_FLASH) begin
            led_d = LED_OFF;
            lcnt_d = 32'h0000_0000;
        end else if (led_q == LED_OFF) begin
            led_d = LED_ON1;
            lcnt_d = (pat == PAT_SEARCH) ? load(T_BLINK_CYC) : load(T_SHORT_CYC);
        end else if (lcnt_q != 32'h0000_0000) begin
            lcnt_d = lcnt_q - 32'h0000_0001;
        end else begin
            unique case (led_q)
                LED_ON1: begin
                    if (pat == PAT_CTX) begin
                        led_d = LED_GAP1;
                        lcnt_d = load(T_SHORT_CYC);
                    end else begin
                        led_d = LED_REST;
                        lcnt_d = (pat == PAT_SEARCH) ? load(T_BLINK_CYC) : load(T_LONG_CYC);
                    end
                end
                LED_GAP1: begin
                    led_d = LED_ON2;
                    lcnt_d = load(T_SHORT_CYC);
                end
                LED_ON2: begin
                    led_d = LED_REST;
                    lcnt_d = load(T_LONG_CYC);
                end
                LED_REST: begin
                    led_d = LED_OFF;
                end
                default: begin
                    led_d = LED_OFF;
                end
            endcase
        end
    end

    always_comb begin
        unique case (pat)
            PAT_STEADY: led_out = 1'b1;
            PAT_FLASH: led_out = flash_q;
            PAT_NONE: led_out = 1'b0;
            default: led_out = (led_q == LED_ON1) || (led_q == LED_ON2);
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            led_q <= LED_OFF;
            lcnt_q <= 32'h0000_0000;
            fcnt_q <= 32'h0000_0000;
            flash_q <= 1'b0;
        end else begin
            led_q <= led_d;
            lcnt_q <= lcnt_d;
            fcnt_q <= fcnt_d;
            flash_q <= flash_d;
        end
    end

    // ------------------------------------------------------------
    // Ring indicator
    // ------------------------------------------------------------
    logic [31:0] rcnt_q, rcnt_d;
    logic rphase_q, rphase_d;
    logic [31:0] ncnt_q, ncnt_d;
    logic notice_q, notice_d;
    logic notice_prev_q;
    logic [31:0] tcnt_q, tcnt_d;
    logic text_d;
    logic ringing;
    logic ring_low;

    assign ringing = ring.voice_ringing || ring.data_ringing;

    always_comb begin
        rcnt_d = rcnt_q;
        rphase_d = rphase_q;
        ncnt_d = ncnt_q;
        notice_d = notice_q;
        tcnt_d = tcnt_q;
        text_d = 1'b0;
        // Voice cadence: low phase first, then high
        if (!ring.voice_ringing) begin
            rphase_d = 1'b0;
            rcnt_d = load(T_RLOW_CYC);
        end else if (rcnt_q != 32'h0000_0000) begin
            rcnt_d = rcnt_q - 32'h0000_0001;
        end else begin
            rphase_d = ~rphase_q;
            rcnt_d = rphase_q ? load(T_RLOW_CYC) : load(T_RHIGH_CYC);
        end
        // Notice pulse, retriggered by each new notice edge
        if (ring.notice && !notice_prev_q) begin
            notice_d = 1'b1;
            ncnt_d = load(T_NOTICE_CYC);
        end else if (notice_q) begin
            if (ncnt_q == 32'h0000_0000) begin
                notice_d = 1'b0;
            end else begin
                ncnt_d = ncnt_q - 32'h0000_0001;
            end
        end
        // Text notice request at ring start and every 5 s
        if (!ringing) begin
            tcnt_d = 32'h0000_0000;
        end else if (tcnt_q == 32'h0000_0000) begin
            text_d = 1'b1;
            tcnt_d = load(T_TEXT_CYC);
        end else begin
            tcnt_d = tcnt_q - 32'h0000_0001;
        end
    end

    assign ring_low = ring.data_ringing
        || ring.call_waiting
        || notice_q
        || (ring.voice_ringing && !rphase_q);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rcnt_q <= 32'h0000_0000;
            rphase_q <= 1'b0;
            ncnt_q <= 32'h0000_0000;
            notice_q <= 1'b0;
            notice_prev_q <= 1'b0;
            tcnt_q <= 32'h0000_0000;
            ring_text_req <= 1'b0;
            ring_indicator_n <= 1'b1;
            burst_led_pin <= 1'b0;
        end else begin
            rcnt_q <= rcnt_d;
            rphase_q <= rphase_d;
            ncnt_q <= ncnt_d;
            notice_q <= notice_d;
            notice_prev_q <= ring.notice;
            tcnt_q <= tcnt_d;
            ring_text_req <= text_d;
            ring_indicator_n <= ~ring_low;
            // Burst marker follows the burst gate for any burst type
            burst_led_pin <= (mode_q == MODE_SYNC) ? tx_burst : led_out;
        end
    end

    assign pin_mode = mode_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_mode_reset: assert property (@(posedge clk) $rose(rst_n) |-> mode_q == MODE_SYNC)
        else $error("mode not 0 after reset");
    chk_sync_follow: assert property (@(posedge clk) disable iff (!rst_n)
        (mode_q == MODE_SYNC && $past(mode_q) == MODE_SYNC) |-> burst_led_pin == $past(tx_burst))
        else $error("sync pin does not follow burst");
    chk_led_off: assert property (@(posedge clk) disable iff (!rst_n)
        (mode_q == MODE_LED && status.powered_off) ##1 (mode_q == MODE_LED) |-> !burst_led_pin)
        else $error("led on while off");
    chk_led_steady: assert property (@(posedge clk) disable iff (!rst_n)
        (mode_q == MODE_LED && status.call_connected && !status.powered_off && !status.low_power)
        ##1 (mode_q == MODE_LED) |-> burst_led_pin)
        else $error("led not steady in call");
    chk_flash_start: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(status.data_exchanged) |=> flash_q)
        else $error("flash not started");
    chk_data_ring: assert property (@(posedge clk) disable iff (!rst_n)
        ring.data_ringing |=> !ring_indicator_n)
        else $error("ring line high during data ring");
    chk_wait_ring: assert property (@(posedge clk) disable iff (!rst_n)
        ring.call_waiting |=> !ring_indicator_n)
        else $error("ring line high during waiting call");
    chk_notice_low: assert property (@(posedge clk) disable iff (!rst_n)
        (ring.notice && !notice_prev_q) |=> notice_q ##1 !ring_indicator_n)
        else $error("notice pulse missing");
    chk_voice_start: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(ring.voice_ringing) |=> ##1 !ring_indicator_n)
        else $error("voice ring does not start low");
    chk_text_start: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(ringing) |=> ring_text_req)
        else $error("ring text not requested");
    chk_idle_high: assert property (@(posedge clk) disable iff (!rst_n)
        (!ring_low) |=> ring_indicator_n)
        else $error("ring line low when idle");
endmodule
`default_nettype wire

/* verification/ssr_host_model.sv */
// Host side partner: counts ring notices, latches wake requests, buffers the LED
// Assumes it shares clk and rst_n with the output block
`timescale 1ns/1ps
`default_nettype none
module ssr_host_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clr,
    input wire logic sleeping,
    input wire logic ring_indicator_n,
    input wire logic ring_text_req,
    input wire logic burst_led_pin,
    output logic [7:0] text_count,
    output logic woken,
    output logic led_lit
);
    assign led_lit = burst_led_pin;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            text_count <= 8'h00;
            woken <= 1'b0;
        end else if (clr) begin
            text_count <= 8'h00;
        end else begin
            text_count <= text_count + {7'h00, ring_text_req};
            woken <= woken | (sleeping & ~ring_indicator_n);
        end
    end
endmodule
`default_nettype wire

/* verification/ssr_outputs_test.sv */
// Self-checking bench for the burst/LED pin and ring indicator block
// Assumes shortened phase counts and the host model beside the block
`timescale 1ns/1ps
`default_nettype none
module ssr_outputs_test;
    import ssr_pkg::*;
    typedef struct {int c; int sel; logic [7:0] v;} ssr_note_t;
    logic clk = 0, rst_n = 0, mode_wr = 0, mode_value = 0, tx_burst = 0;
    logic clr = 0, sleeping = 1, pin_mode, burst_led_pin, ring_indicator_n;
    logic ring_text_req, woken, led_lit;
    logic [7:0] text_count;
    ssr_status_t status = '0;
    ssr_ring_t ring = '0;
    int errors = 0, cmp_count = 0, cyc = 0;
    ssr_note_t q[$];
    always #20 clk = ~clk;
    ssr_outputs #(.T_BLINK_CYC(20), .T_SHORT_CYC(5), .T_LONG_CYC(40), .T_RLOW_CYC(10),
        .T_RHIGH_CYC(40)) u_dut (
        .clk(clk), .rst_n(rst_n), .mode_wr(mode_wr), .mode_value(mode_value),
        .tx_burst(tx_burst), .status(status), .ring(ring), .pin_mode(pin_mode),
        .burst_led_pin(burst_led_pin), .ring_indicator_n(ring_indicator_n),
        .ring_text_req(ring_text_req));
    ssr_host_model u_host (.clk(clk), .rst_n(rst_n), .clr(clr), .sleeping(sleeping),
        .ring_indicator_n(ring_indicator_n), .ring_text_req(ring_text_req),
        .burst_led_pin(burst_led_pin), .text_count(text_count), .woken(woken),
        .led_lit(led_lit));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk);
            #2;
        end
    endtask
    task automatic expect_at(input int sel, input int off, input logic [7:0] v);
        ssr_note_t n;
        n.c = cyc + off;
        n.sel = sel;
        n.v = v;
        q.push_back(n);
    endtask
    task automatic cmp_level(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_total(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic set_mode(input logic v);
        mode_wr = 1;
        mode_value = v;
        expect_at(2, 2, {7'h00, v});
        tick(1);
        mode_wr = 0;
        tick(2);
    endtask
    // Starts from the dark state, then applies one status mix
    task automatic show(input ssr_status_t s, input int o[4], input logic [3:0] v, input int n);
        status = 7'h40;
        tick(3);
        status = s;
        foreach (o[i]) expect_at(0, o[i], {7'h00, v[i]});
        tick(n);
    endtask
    task automatic ring_case(input ssr_ring_t r, input int o[4], input logic [3:0] v,
        input int n, input logic [7:0] texts);
        clr = 1;
        tick(1);
        clr = 0;
        ring = r;
        foreach (o[i]) expect_at(1, o[i], {7'h00, v[i]});
        expect_at(3, n, texts);
        tick(n);
        ring = '0;
        expect_at(1, 19, 8'h01);
        tick(20);
    endtask
    task automatic finish_test();
        if (errors == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Result watcher
    // ----------------------------------------
    always @(posedge clk) begin
        #1;
        cyc++;
        while (q.size() > 0 && q[0].c <= cyc) begin
            case (q[0].sel)
                0: cmp_level(burst_led_pin, q[0].v[0]);
                1: cmp_level(ring_indicator_n, q[0].v[0]);
                2: cmp_level(pin_mode, q[0].v[0]);
                3: cmp_total(text_count, q[0].v);
                default: cmp_level(woken, q[0].v[0]);
            endcase
            void'(q.pop_front());
        end
    end
    initial begin
        #200000;
        errors++;
        finish_test();
    end
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        int len;
        void'($urandom(80395));
        tick(5);
        rst_n = 1;
        expect_at(0, 1, 8'h00);
        expect_at(1, 1, 8'h01);
        expect_at(2, 1, 8'h00);
        expect_at(4, 1, 8'h00);
        tick(2);
        status = 7'h08;
        for (int i = 0; i < 2; i++) begin
            len = 2 + $urandom_range(6);
            tx_burst = 1;
            for (int k = 2; k <= len; k++) expect_at(0, k, 8'h01);
            expect_at(0, len + 2, 8'h00);
            tick(len);
            tx_burst = 0;
            tick(4);
        end
        set_mode(1);
        show(7'h1c, '{4, 11, 16, 35}, 4'b0101, 60);
        show(7'h10, '{10, 33, 56, 58}, 4'b1101, 60);
        show(7'h08, '{4, 25, 45, 50}, 4'b1001, 56);
        show(7'h0e, '{3, 9, 11, 12}, 4'b1111, 14);
        show(7'h1d, '{5, 30, 60, 90}, 4'b1111, 92);
        tx_burst = 1;
        show(7'h21, '{3, 20, 40, 60}, 4'b0000, 62);
        tx_burst = 0;
        ring_case(4'b1000, '{5, 20, 45, 60}, 4'b0110, 80, 8'h02);
        expect_at(4, 1, 8'h01);
        ring_case(4'b0100, '{3, 30, 70, 110}, 4'b0000, 120, 8'h03);
        ring_case(4'b0010, '{3, 20, 40, 60}, 4'b0000, 62, 8'h00);
        ring.notice = 1;
        expect_at(1, 4, 8'h00);
        expect_at(1, 15, 8'h00);
        expect_at(1, 25, 8'h01);
        tick(1);
        ring.notice = 0;
        tick(5);
        ring.notice = 1;
        tick(1);
        ring.notice = 0;
        tick(30);
        set_mode(0);
        status = 7'h01;
        expect_at(0, 2, 8'h00);
        ring.data_ringing = 1;
        tick(5);
        rst_n = 0;
        expect_at(0, 1, 8'h00);
        expect_at(1, 1, 8'h01);
        expect_at(2, 1, 8'h00);
        tick(3);
        rst_n = 1;
        expect_at(1, 1, 8'h00);
        expect_at(2, 1, 8'h00);
        expect_at(4, 1, 8'h00);
        expect_at(4, 2, 8'h01);
        tick(2);
        finish_test();
    end
endmodule
`default_nettype wire
